/* File: include/gors_defines.svh */
`ifndef GORS_DEFINES_SVH
`define GORS_DEFINES_SVH
`define GORS_ADDR_Y_OFS_HI 8'h15
`define GORS_ADDR_Y_OFS_LO 8'h16
`define GORS_ADDR_Z_OFS_HI 8'h17
`define GORS_ADDR_Z_OFS_LO 8'h18
`define GORS_ADDR_RATE_DIV 8'h19
`define GORS_ADDR_CONFIG 8'h1A
`define GORS_RST_OFS 8'h00
`define GORS_RST_RATE_DIV 8'h00
`define GORS_RST_CONFIG 8'h80
`define GORS_CFG_SPARE_BIT 7
`define GORS_CFG_POLICY_BIT 6
`define GORS_CFG_PLACE_MSB 5
`define GORS_CFG_PLACE_LSB 3
`define GORS_CFG_LPF_MSB 2
`define GORS_CFG_LPF_LSB 0
`define GORS_CLK_HZ 25000000
`define GORS_RATE_1K_HZ 1000
`define GORS_RATE_8K_HZ 8000
`define GORS_RATE_32K_HZ 32000
`define GORS_CYC_8K (`GORS_CLK_HZ / `GORS_RATE_8K_HZ)
`define GORS_CYC_32K (`GORS_CLK_HZ / `GORS_RATE_32K_HZ)
`define GORS_IDX_GYRO_Y 2
`define GORS_IDX_GYRO_Z 3
`endif

/* File: include/gors_pkg.sv */
package gors_pkg;
	// word 0 temperature, 1..3 gyro X/Y/Z, 4..6 accel X/Y/Z
	typedef logic [6:0][15:0] gors_sample_type;
	typedef struct packed {
		logic spare;
		logic keep_on_full;
		logic [2:0] place_sel;
		logic [2:0] lpf_set;
	} gors_config_type;
	typedef enum logic [1:0] {
		GORS_RATE_1K = 2'b00,
		GORS_RATE_8K = 2'b01,
		GORS_RATE_32K = 2'b10
	} gors_rate_type;
endpackage : gors_pkg

/* File: verilog/gors_top.sv */
`timescale 1ns/1ns
`include "gors_defines.svh"
module gors_top
	import gors_pkg::*;
#(
	parameter int CYC_1K = `GORS_CLK_HZ / `GORS_RATE_1K_HZ
) (
	// clock and reset
	input wire logic CORE_CLK,
	input wire logic ARST_N,
	input wire logic CLK_EN,
	// register port from the serial interface logic
	input wire logic REG_WR_EN,
	input wire logic REG_RD_EN,
	input wire logic [7:0] REG_ADDR,
	input wire logic [7:0] REG_WDATA,
	output logic [7:0] REG_RDATA,
	// gyro configuration bypass field
	input wire logic [1:0] FILTER_BYPASS_FIELD,
	// frame sync pin
	input wire logic FRAME_SYNC_INPUT,
	// raw samples from the filter path
	input wire gors_sample_type RAW_SAMPLE,
	// results and rate
	output gors_sample_type RESULT_SAMPLE,
	output logic SAMPLE_STROBE,
	output gors_rate_type INTERNAL_RATE,
	output logic FILTER_ACTIVE,
	output logic [2:0] LOWPASS_SETTING,
	// fifo write side
	input wire logic FIFO_FULL,
	output logic FIFO_WRITE,
	output logic FIFO_DROP_OLDEST,
	output logic FIFO_DISCARD,
	output gors_sample_type FIFO_DATA
);

	// register file
	logic [7:0] y_hi_r, y_lo_r, z_hi_r, z_lo_r, div_r, rdata_r;
	logic [7:0] y_hi_nxt, y_lo_nxt, z_hi_nxt, z_lo_nxt, div_nxt, rdata_nxt;
	gors_config_type cfg_r, cfg_nxt;
	logic [15:0] y_axis_bias_word, z_axis_bias_word;

	always_comb begin
		y_hi_nxt = y_hi_r;
		y_lo_nxt = y_lo_r;
		z_hi_nxt = z_hi_r;
		z_lo_nxt = z_lo_r;
		div_nxt = div_r;
		cfg_nxt = cfg_r;
		rdata_nxt = rdata_r;
		if (REG_WR_EN) begin
			unique case (REG_ADDR)
				`GORS_ADDR_Y_OFS_HI: y_hi_nxt = REG_WDATA;
				`GORS_ADDR_Y_OFS_LO: y_lo_nxt = REG_WDATA;
				`GORS_ADDR_Z_OFS_HI: z_hi_nxt = REG_WDATA;
				`GORS_ADDR_Z_OFS_LO: z_lo_nxt = REG_WDATA;
				`GORS_ADDR_RATE_DIV: div_nxt = REG_WDATA;
				`GORS_ADDR_CONFIG: cfg_nxt = gors_config_type'(REG_WDATA);
				default: ;
			endcase
		end
		if (REG_RD_EN) begin
			unique case (REG_ADDR)
				`GORS_ADDR_Y_OFS_HI: rdata_nxt = y_hi_r;
				`GORS_ADDR_Y_OFS_LO: rdata_nxt = y_lo_r;
				`GORS_ADDR_Z_OFS_HI: rdata_nxt = z_hi_r;
				`GORS_ADDR_Z_OFS_LO: rdata_nxt = z_lo_r;
				`GORS_ADDR_RATE_DIV: rdata_nxt = div_r;
				`GORS_ADDR_CONFIG: rdata_nxt = 8'(cfg_r);
				default: rdata_nxt = 8'h00;
			endcase
		end
	end

	always_ff @(posedge CORE_CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			y_hi_r <= `GORS_RST_OFS;
			y_lo_r <= `GORS_RST_OFS;
			z_hi_r <= `GORS_RST_OFS;
			z_lo_r <= `GORS_RST_OFS;
			div_r <= `GORS_RST_RATE_DIV;
			cfg_r <= gors_config_type'(`GORS_RST_CONFIG);
			rdata_r <= 8'h00;
		end else if (CLK_EN) begin
			y_hi_r <= y_hi_nxt;
			y_lo_r <= y_lo_nxt;
			z_hi_r <= z_hi_nxt;
			z_lo_r <= z_lo_nxt;
			div_r <= div_nxt;
			cfg_r <= cfg_nxt;
			rdata_r <= rdata_nxt;
		end
	end

	// both bytes joined live, so a half-written word is used as it stands
	assign y_axis_bias_word = {y_hi_r, y_lo_r};
	assign z_axis_bias_word = {z_hi_r, z_lo_r};
	assign REG_RDATA = rdata_r;

	// rate selection
	gors_rate_type rate_sel;
	logic lpf_mid, div_active;
	always_comb begin
		lpf_mid = (cfg_r.lpf_set != 3'h0) && (cfg_r.lpf_set != 3'h7);
		if (FILTER_BYPASS_FIELD != 2'b00) begin
			rate_sel = GORS_RATE_32K;
		end else if (lpf_mid) begin
			rate_sel = GORS_RATE_1K;
		end else begin
			rate_sel = GORS_RATE_8K;
		end
		div_active = (FILTER_BYPASS_FIELD == 2'b00) && lpf_mid;
	end
	assign INTERNAL_RATE = rate_sel;
	assign FILTER_ACTIVE = (FILTER_BYPASS_FIELD == 2'b00);
	assign LOWPASS_SETTING = FILTER_ACTIVE ? cfg_r.lpf_set : 3'h0;

	// internal tick and divided strobe
	logic [14:0] tick_cnt_r, tick_cnt_nxt, tick_top;
	logic [7:0] div_cnt_r, div_cnt_nxt;
	logic strobe_r, strobe_nxt, tick;
	always_comb begin
		unique case (rate_sel)
			GORS_RATE_1K: tick_top = 15'(CYC_1K - 1);
			GORS_RATE_8K: tick_top = 15'(`GORS_CYC_8K - 1);
			GORS_RATE_32K: tick_top = 15'(`GORS_CYC_32K - 1);
			default: tick_top = 15'(CYC_1K - 1);
		endcase
		tick = (tick_cnt_r >= tick_top);
		tick_cnt_nxt = tick ? 15'h0000 : 15'(tick_cnt_r + 15'h0001);
		div_cnt_nxt = div_cnt_r;
		strobe_nxt = 1'b0;
		if (tick) begin
			if (!div_active || div_cnt_r >= div_r) begin
				div_cnt_nxt = 8'h00;
				strobe_nxt = 1'b1;
			end else begin
				div_cnt_nxt = 8'(div_cnt_r + 8'h01);
			end
		end
	end

	always_ff @(posedge CORE_CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			tick_cnt_r <= 15'h0000;
			div_cnt_r <= 8'h00;
			strobe_r <= 1'b0;
		end else if (CLK_EN) begin
			tick_cnt_r <= tick_cnt_nxt;
			div_cnt_r <= div_cnt_nxt;
			strobe_r <= strobe_nxt;
		end
	end
	assign SAMPLE_STROBE = strobe_r;

	// frame sync: two-stage synchroniser, then a one-shot latch
	logic fs_meta_r, fs_sync_r, fs_latch_r, fs_armed_r;
	logic fs_latch_nxt, fs_armed_nxt;
	always_comb begin
		fs_latch_nxt = fs_latch_r;
		fs_armed_nxt = fs_armed_r;
		if (fs_armed_r && (fs_sync_r != fs_latch_r)) begin
			fs_latch_nxt = fs_sync_r;
			fs_armed_nxt = 1'b0;
		end
		// the strobe re-arms; a level still differing is taken after that
		if (strobe_nxt) begin
			fs_armed_nxt = 1'b1;
		end
	end

	always_ff @(posedge CORE_CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			fs_meta_r <= 1'b0;
			fs_sync_r <= 1'b0;
			fs_latch_r <= 1'b0;
			fs_armed_r <= 1'b1;
		end else if (CLK_EN) begin
			fs_meta_r <= FRAME_SYNC_INPUT;
			fs_sync_r <= fs_meta_r;
			fs_latch_r <= fs_latch_nxt;
			fs_armed_r <= fs_armed_nxt;
		end
	end

	// result words and fifo write
	gors_sample_type res_r, res_nxt, fifo_r, fifo_nxt;
	logic wr_r, wr_nxt, drop_r, drop_nxt, disc_r, disc_nxt;
	always_comb begin
		res_nxt = res_r;
		fifo_nxt = fifo_r;
		wr_nxt = 1'b0;
		drop_nxt = 1'b0;
		disc_nxt = 1'b0;
		if (strobe_nxt) begin
			res_nxt = RAW_SAMPLE;
			// sums wrap in 16 bits, no saturation
			res_nxt[`GORS_IDX_GYRO_Y] = 16'(RAW_SAMPLE[`GORS_IDX_GYRO_Y] + y_axis_bias_word);
			res_nxt[`GORS_IDX_GYRO_Z] = 16'(RAW_SAMPLE[`GORS_IDX_GYRO_Z] + z_axis_bias_word);
			for (int k = 0; k < 7; k++) begin
				if (cfg_r.place_sel == 3'(k + 1)) begin
					res_nxt[k][0] = fs_latch_nxt;
				end
			end
			if (FIFO_FULL && cfg_r.keep_on_full) begin
				disc_nxt = 1'b1;
			end else begin
				wr_nxt = 1'b1;
				drop_nxt = FIFO_FULL;
				fifo_nxt = res_nxt;
			end
		end
	end

	always_ff @(posedge CORE_CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			res_r <= '0;
			fifo_r <= '0;
			wr_r <= 1'b0;
			drop_r <= 1'b0;
			disc_r <= 1'b0;
		end else if (CLK_EN) begin
			res_r <= res_nxt;
			fifo_r <= fifo_nxt;
			wr_r <= wr_nxt;
			drop_r <= drop_nxt;
			disc_r <= disc_nxt;
		end
	end
	assign RESULT_SAMPLE = res_r;
	assign FIFO_DATA = fifo_r;
	assign FIFO_WRITE = wr_r;
	assign FIFO_DROP_OLDEST = drop_r;
	assign FIFO_DISCARD = disc_r;

	// checks
	default clocking cb @(posedge CORE_CLK); endclocking
	default disable iff (!ARST_N);

	a_ywrite_readback: assert property (
		CLK_EN && REG_WR_EN && REG_ADDR == `GORS_ADDR_Y_OFS_HI ##1 !REG_WR_EN ##1
		CLK_EN && REG_RD_EN && !REG_WR_EN && REG_ADDR == `GORS_ADDR_Y_OFS_HI
		|=> REG_RDATA == $past(REG_WDATA, 3))
		else $error("y offset high byte not read back");
	a_zword_join: assert property (
		CLK_EN && REG_WR_EN && REG_ADDR == `GORS_ADDR_Z_OFS_LO
		|=> z_axis_bias_word[7:0] == $past(REG_WDATA))
		else $error("z offset low byte not joined");
	a_gyro_y_sum: assert property (
		CLK_EN && strobe_nxt |=> RESULT_SAMPLE[`GORS_IDX_GYRO_Y][15:1] ==
		$past(16'(RAW_SAMPLE[`GORS_IDX_GYRO_Y] + y_axis_bias_word)) >> 1)
		else $error("y sum wrong");
	a_div_bypass: assert property (
		CLK_EN && tick && !div_active |=> SAMPLE_STROBE && div_cnt_r == 8'h00)
		else $error("divider counting while inactive");
	a_fifo_discard: assert property (
		CLK_EN && strobe_nxt && FIFO_FULL && cfg_r.keep_on_full
		|=> FIFO_DISCARD && !FIFO_WRITE)
		else $error("full fifo not discarded");
	a_fifo_overwrite: assert property (
		CLK_EN && strobe_nxt && FIFO_FULL && !cfg_r.keep_on_full
		|=> FIFO_WRITE && FIFO_DROP_OLDEST)
		else $error("full fifo not overwritten");
	a_sync_hold: assert property (
		!fs_armed_r |=> $stable(fs_latch_r))
		else $error("latched sync toggled twice");
	a_write_pace: assert property (
		FIFO_WRITE || FIFO_DISCARD |-> SAMPLE_STROBE)
		else $error("fifo write off the strobe");
	a_rate_bypass: assert property (
		FILTER_BYPASS_FIELD != 2'b00 |-> INTERNAL_RATE == GORS_RATE_32K && !FILTER_ACTIVE)
		else $error("bypass rate wrong");
	a_config_reset: assert property (
		$rose(ARST_N) |-> cfg_r.spare)
		else $error("config spare bit not set at reset");

	c_strobe: cover property (SAMPLE_STROBE ##[1:300] SAMPLE_STROBE);
	c_discard: cover property (FIFO_DISCARD);
	c_overwrite: cover property (FIFO_DROP_OLDEST);
	c_sync_toggle: cover property ($changed(fs_latch_r) && cfg_r.place_sel != 3'h0);

endmodule : gors_top

/* File: test/gors_host_model.sv */
`timescale 1ns/1ns
module gors_host_model (
	// clock
	input logic clk,
	// register port
	output logic wr_en,
	output logic rd_en,
	output logic [7:0] addr,
	output logic [7:0] wdata,
	input logic [7:0] rdata
);
	initial begin
		wr_en = 1'b0;
		rd_en = 1'b0;
		addr = 8'h00;
		wdata = 8'h00;
	end
	// released enables drop and address and data invert, so a read's release can restore an old wdata
	task automatic release_bus();
		wr_en = 1'b0;
		rd_en = 1'b0;
		addr = ~addr;
		wdata = ~wdata;
	endtask : release_bus
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		#1;
		wr_en = 1'b1;
		addr = a;
		wdata = d;
		@(posedge clk);
		#1;
		release_bus();
	endtask : wr
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge clk);
		#1;
		rd_en = 1'b1;
		addr = a;
		@(posedge clk);
		#1;
		d = rdata;
		release_bus();
	endtask : rd
	// spare bit always cleared at setup
	task automatic cfg(input logic [6:0] v);
		wr(8'h1A, {1'b0, v});
	endtask : cfg
endmodule : gors_host_model

/* File: test/gors_top_tb.sv */
`timescale 1ns/1ns
`include "gors_defines.svh"
module gors_top_tb import gors_pkg::*; ;
	logic clk = 1'b0;
	logic arst_n = 1'b0;
	logic clk_en = 1'b1;
	logic [1:0] bypass = 2'b00;
	logic frame_sync_input = 1'b0;
	logic full = 1'b0;
	gors_sample_type raw = {16'h0E00, 16'h0C00, 16'h0A00, 16'h0800, 16'h0600, 16'h0400, 16'h0200};
	logic [15:0] yofs = 16'h0000;
	logic [15:0] zofs = 16'h0000;
	logic wr_en, rd_en, strobe, fwr, fdrop, fdisc, active;
	logic [7:0] addr, wdata, rdata, d;
	logic [2:0] lpf;
	gors_rate_type rate;
	gors_sample_type res, fdata;
	int errors = 0;
	int checked = 0;
	int cycles = 0;
	int n;
	always #20 clk = ~clk;
	gors_host_model host_u (.clk(clk), .wr_en(wr_en), .rd_en(rd_en), .addr(addr),
		.wdata(wdata), .rdata(rdata));
	// short 1k period keeps the run small
	gors_top #(.CYC_1K(50)) dut_u (.CORE_CLK(clk), .ARST_N(arst_n), .CLK_EN(clk_en),
		.REG_WR_EN(wr_en), .REG_RD_EN(rd_en), .REG_ADDR(addr), .REG_WDATA(wdata),
		.REG_RDATA(rdata), .FILTER_BYPASS_FIELD(bypass), .FRAME_SYNC_INPUT(frame_sync_input),
		.RAW_SAMPLE(raw), .RESULT_SAMPLE(res), .SAMPLE_STROBE(strobe), .INTERNAL_RATE(rate),
		.FILTER_ACTIVE(active), .LOWPASS_SETTING(lpf), .FIFO_FULL(full), .FIFO_WRITE(fwr),
		.FIFO_DROP_OLDEST(fdrop), .FIFO_DISCARD(fdisc), .FIFO_DATA(fdata));
	task automatic give_verdict();
		$display("errors=%0d checked=%0d", errors, checked);
		if (errors == 0 && checked > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask : give_verdict
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 60000) begin
			errors = errors + 1;
			give_verdict();
		end
	end
	task automatic chk_v(input string nm, input logic [111:0] e, input logic [111:0] g);
		checked++;
		if (g !== e) begin
			errors++;
			$display("[FAIL] %s expected %0h seen %0h", nm, e, g);
		end
	endtask : chk_v
	function automatic gors_sample_type exp_res(input int s, input logic latch);
		gors_sample_type e;
		e = raw;
		e[2] = raw[2] + yofs;
		e[3] = raw[3] + zofs;
		if (s > 0) e[s-1][0] = latch;
		return e;
	endfunction : exp_res
	// returns in the strobe cycle, n holds the spacing
	task automatic wait_strobe();
		n = 0;
		do begin
			@(posedge clk);
			#1;
			n++;
		end while (strobe !== 1'b1 && n < 4000);
		chk_v("strobe", 1'b1, strobe);
	endtask : wait_strobe
	task automatic t_regs();
		for (int i = 0; i < 6; i++) begin
			host_u.rd(8'(8'h15 + i), d);
			chk_v("reset value", (i == 5) ? `GORS_RST_CONFIG : `GORS_RST_OFS, d);
			host_u.wr(8'(8'h15 + i), 8'(8'hA5 ^ i));
		end
		host_u.wr(8'h20, 8'h5A);
		for (int i = 0; i < 6; i++) begin
			host_u.rd(8'(8'h15 + i), d);
			chk_v("readback", 8'(8'hA5 ^ i), d);
		end
		host_u.rd(8'h20, d);
		chk_v("unmapped", 8'h00, d);
	endtask : t_regs
	// a write while the clock enable is low must be lost
	task automatic t_freeze();
		clk_en = 1'b0;
		host_u.wr(`GORS_ADDR_Z_OFS_HI, 8'h3C);
		clk_en = 1'b1;
		host_u.rd(`GORS_ADDR_Z_OFS_HI, d);
		chk_v("frozen write", 8'(8'hA5 ^ 2), d);
	endtask : t_freeze
	task automatic t_offset();
		yofs = 16'hFFF0;
		zofs = 16'h0123;
		host_u.wr(`GORS_ADDR_Y_OFS_HI, yofs[15:8]);
		host_u.rd(`GORS_ADDR_Y_OFS_HI, d);
		chk_v("y high readback", yofs[15:8], d);
		host_u.wr(`GORS_ADDR_Y_OFS_LO, yofs[7:0]);
		host_u.wr(`GORS_ADDR_Z_OFS_HI, zofs[15:8]);
		host_u.wr(`GORS_ADDR_Z_OFS_LO, zofs[7:0]);
		host_u.wr(`GORS_ADDR_RATE_DIV, 8'h00);
		host_u.cfg(7'h01);
		wait_strobe();
		wait_strobe();
		chk_v("result", exp_res(0, 1'b0), res);
		chk_v("fifo data", exp_res(0, 1'b0), fdata);
		yofs[7:0] = 8'h07;
		host_u.wr(`GORS_ADDR_Y_OFS_LO, 8'h07);
		wait_strobe();
		chk_v("result", exp_res(0, 1'b0), res);
	endtask : t_offset
	task automatic t_sync();
		for (int s = 1; s < 8; s++) begin
			host_u.cfg({1'b0, 3'(s), 3'd1});
			wait_strobe();
			wait_strobe();
			frame_sync_input = 1'b1;
			repeat (2) @(posedge clk);
			#1;
			frame_sync_input = 1'b0;
			wait_strobe();
			chk_v("sync word", exp_res(s, 1'b1), res);
		end
		wait_strobe();
		chk_v("sync rearm", exp_res(7, 1'b0), res);
	endtask : t_sync
	task automatic t_fifo();
		full = 1'b1;
		host_u.cfg(7'h41);
		wait_strobe();
		chk_v("discard", 1'b1, fdisc);
		chk_v("write", 1'b0, fwr);
		host_u.cfg(7'h01);
		wait_strobe();
		chk_v("write", 1'b1, fwr);
		chk_v("drop oldest", 1'b1, fdrop);
		full = 1'b0;
	endtask : t_fifo
	task automatic t_rate(input logic [1:0] bp, input logic [2:0] l, input logic [7:0] dv,
		input int sp, input gors_rate_type rt);
		bypass = bp;
		host_u.wr(`GORS_ADDR_RATE_DIV, dv);
		host_u.cfg({4'h0, l});
		wait_strobe();
		wait_strobe();
		wait_strobe();
		chk_v("spacing", sp, n);
		chk_v("rate", rt, rate);
		chk_v("filter active", bp == 2'b00, active);
		chk_v("lowpass", (bp == 2'b00) ? l : 3'd0, lpf);
	endtask : t_rate
	initial begin
		repeat (4) @(posedge clk);
		#1;
		arst_n = 1'b1;
		t_regs();
		t_freeze();
		t_offset();
		t_sync();
		t_fifo();
		t_rate(2'b00, 3'd1, 8'd2, 150, GORS_RATE_1K);
		t_rate(2'b00, 3'd6, 8'd0, 50, GORS_RATE_1K);
		t_rate(2'b00, 3'd7, 8'd2, 3125, GORS_RATE_8K);
		t_rate(2'b00, 3'd0, 8'd2, 3125, GORS_RATE_8K);
		t_rate(2'b01, 3'd3, 8'd2, 781, GORS_RATE_32K);
		t_rate(2'b10, 3'd3, 8'd2, 781, GORS_RATE_32K);
		give_verdict();
	end
endmodule : gors_top_tb
